// ==== core/cpe_enumerator.sv ====
// cache parameter enumerator: answers the identification query for the cache leaf
// Functional notes
// - leaf 4 returns deterministic cache parameters
// - sub-index from 0 selects the cache level
// - word a bits 4:0 give cache type
// - word a bits 7:5 give level from 1
// - self-init bit 8, fully-assoc bit 9, 13:10 zero
// - bits 25:14 sharing processors minus one
// - bits 31:26 package cores minus one
// - word b: line, partitions, ways minus one
// - word c sets minus one, word d reserved
// - leaves 4 to 7FFFFFFF hidden when bit 22 set
`timescale 1ns/100ps
module cpe_enumerator (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic query_i, // one-cycle query strobe
	input wire logic [31:0] func_sel_i, // function selector register
	input wire logic [31:0] sub_idx_i, // sub-index register
	input wire logic misc_wr_i, // write strobe, feature-enable register
	input wire logic [31:0] misc_wdata_i,
	output logic [31:0] misc_rdata_o, // feature-enable register read back
	output logic ans_valid_o, // one-cycle answer strobe
	output logic leaf_hit_o, // last query was answered by this leaf
	output logic [31:0] cache_descriptor_word_a_o,
	output logic [31:0] cache_geometry_word_b_o,
	output logic [31:0] cache_sets_word_c_o,
	output logic [31:0] cache_spare_word_d_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] misc_r; // misc feature-enable register
	logic [31:0] misc_nxt;
	logic valid_r; // answer strobe
	logic hit_r; // answered by this leaf
	logic [31:0] word_a_r; // result words
	logic [31:0] word_b_r;
	logic [31:0] word_c_r;
	logic [31:0] word_a_nxt;
	logic [31:0] word_b_nxt;
	logic [31:0] word_c_nxt;
	logic [31:0] idx_r; // sub-index of the last query, kept for checking
	logic [31:0] func_r; // function of the last query, kept for checking

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic limit_set; // legacy leaf limit bit
	logic gated_range; // leaf lies in the gated range
	logic leaf_visible; // leaf may be answered
	logic cache_hit; // query addresses the cache leaf and it is visible
	cpe_pkg::cpe_level_t lvl; // selected level from the table

	assign limit_set = misc_r[cpe_pkg::CPE_LIMIT_BIT];
	assign gated_range = (func_sel_i > cpe_pkg::CPE_GATED_LO) &&
		(func_sel_i < cpe_pkg::CPE_GATED_HI);
	// the limit bit hides the whole gated range, not just the cache leaf
	assign leaf_visible = !(gated_range && limit_set);
	assign cache_hit = (func_sel_i == cpe_pkg::CPE_LEAF_CACHE) && leaf_visible;

	// ----------------------------------------------------------------
	// level lookup
	// ----------------------------------------------------------------
	cpe_level_rom u_rom (
		.sub_idx_i(sub_idx_i),
		.level_o(lvl)
	);

	// ----------------------------------------------------------------
	// result word assembly
	// ----------------------------------------------------------------
	// a miss answers all zero, which also reads as the null cache type
	assign word_a_nxt = cache_hit ?
		{lvl.cores_m1, lvl.share_m1, 4'h0, lvl.fully_assoc, lvl.self_init,
			lvl.level, lvl.ctype} : 32'h0000_0000;
	assign word_b_nxt = cache_hit ?
		{lvl.ways_m1, lvl.part_m1, lvl.line_m1} : 32'h0000_0000;
	assign word_c_nxt = cache_hit ? lvl.sets_m1 : 32'h0000_0000;

	// software write replaces the whole register
	assign misc_nxt = misc_wr_i ? misc_wdata_i : misc_r;

	// ----------------------------------------------------------------
	// feature-enable register
	// ----------------------------------------------------------------
	// a write in the same cycle as a query takes effect for later queries only
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			misc_r <= cpe_pkg::CPE_MISC_RST;
		else
			misc_r <= misc_nxt;
	end

	// ----------------------------------------------------------------
	// answer strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			valid_r <= 1'b0;
		else
			valid_r <= query_i;
	end

	// ----------------------------------------------------------------
	// result registers: loaded per query, held until the next one
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			hit_r <= 1'b0;
			word_a_r <= 32'h0000_0000;
			word_b_r <= 32'h0000_0000;
			word_c_r <= 32'h0000_0000;
			idx_r <= 32'h0000_0000;
			func_r <= 32'h0000_0000;
		end
		else if (query_i)
		begin
			hit_r <= cache_hit;
			word_a_r <= word_a_nxt;
			word_b_r <= word_b_nxt;
			word_c_r <= word_c_nxt;
			idx_r <= sub_idx_i;
			func_r <= func_sel_i;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign misc_rdata_o = misc_r;
	assign ans_valid_o = valid_r;
	assign leaf_hit_o = hit_r;
	assign cache_descriptor_word_a_o = word_a_r;
	assign cache_geometry_word_b_o = word_b_r;
	assign cache_sets_word_c_o = word_c_r;
	// reserved word is constant zero; no flip-flop is spent on it
	assign cache_spare_word_d_o = 32'h0000_0000;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// answer strobe follows every query by exactly one cycle, once
	property p_answer_timing;
		@(posedge clk_i) disable iff (srst_i)
		query_i |=> ans_valid_o ##1 (!ans_valid_o || $past(query_i));
	endproperty
	a_answer_timing: assert property (p_answer_timing)
		else $error("answer strobe not one cycle after query");

	// a visible cache query within the table returns that level's type and level
	property p_level_select;
		@(posedge clk_i) disable iff (srst_i)
		(query_i && func_sel_i == cpe_pkg::CPE_LEAF_CACHE && !limit_set &&
			sub_idx_i < 32'(cpe_pkg::CPE_NUM_LEVELS)) |=>
		leaf_hit_o && cache_descriptor_word_a_o[4:0] == cpe_pkg::CPE_LEVELS[idx_r[1:0]].ctype &&
			cache_descriptor_word_a_o[7:5] == cpe_pkg::CPE_LEVELS[idx_r[1:0]].level;
	endproperty
	a_level_select: assert property (p_level_select)
		else $error("selected level type or number wrong");

	// reported type never takes a reserved code
	property p_type_legal;
		@(posedge clk_i) disable iff (srst_i)
		ans_valid_o |-> cache_descriptor_word_a_o[4:0] <= cpe_pkg::CPE_TYPE_UNIFIED;
	endproperty
	a_type_legal: assert property (p_type_legal)
		else $error("reserved cache type reported");

	// a real cache reports a level of at least one; null reports level zero
	property p_level_nonzero;
		@(posedge clk_i) disable iff (srst_i)
		ans_valid_o |-> ((cache_descriptor_word_a_o[4:0] != cpe_pkg::CPE_TYPE_NULL) ==
			(cache_descriptor_word_a_o[7:5] != 3'h0));
	endproperty
	a_level_nonzero: assert property (p_level_nonzero)
		else $error("cache level number inconsistent with type");

	// reserved bits 13:10 stay zero and flags match the table
	property p_flags;
		@(posedge clk_i) disable iff (srst_i)
		(ans_valid_o && leaf_hit_o && idx_r < 32'(cpe_pkg::CPE_NUM_LEVELS)) |->
		cache_descriptor_word_a_o[13:10] == 4'h0 &&
			cache_descriptor_word_a_o[8] == cpe_pkg::CPE_LEVELS[idx_r[1:0]].self_init &&
			cache_descriptor_word_a_o[9] == cpe_pkg::CPE_LEVELS[idx_r[1:0]].fully_assoc;
	endproperty
	a_flags: assert property (p_flags)
		else $error("flag or reserved bits of word a wrong");

	// sharing and core counts sit in their fields
	property p_topology;
		@(posedge clk_i) disable iff (srst_i)
		(ans_valid_o && leaf_hit_o && idx_r < 32'(cpe_pkg::CPE_NUM_LEVELS)) |->
		cache_descriptor_word_a_o[25:14] == cpe_pkg::CPE_LEVELS[idx_r[1:0]].share_m1 &&
			cache_descriptor_word_a_o[31:26] == cpe_pkg::CPE_LEVELS[idx_r[1:0]].cores_m1;
	endproperty
	a_topology: assert property (p_topology)
		else $error("sharing or core count field wrong");

	// geometry word and sets word match the selected level
	property p_geometry;
		@(posedge clk_i) disable iff (srst_i)
		(ans_valid_o && leaf_hit_o && idx_r < 32'(cpe_pkg::CPE_NUM_LEVELS)) |->
		cache_geometry_word_b_o[11:0] == cpe_pkg::CPE_LEVELS[idx_r[1:0]].line_m1 &&
			cache_geometry_word_b_o[21:12] == cpe_pkg::CPE_LEVELS[idx_r[1:0]].part_m1 &&
			cache_geometry_word_b_o[31:22] == cpe_pkg::CPE_LEVELS[idx_r[1:0]].ways_m1 &&
			cache_sets_word_c_o == cpe_pkg::CPE_LEVELS[idx_r[1:0]].sets_m1;
	endproperty
	a_geometry: assert property (p_geometry)
		else $error("geometry or sets word wrong");

	// with the limit bit set, a gated leaf gets no answer from this block
	property p_leaf_hidden;
		@(posedge clk_i) disable iff (srst_i)
		(query_i && limit_set && func_sel_i > cpe_pkg::CPE_GATED_LO &&
			func_sel_i < cpe_pkg::CPE_GATED_HI) |=>
		!leaf_hit_o && cache_descriptor_word_a_o == 32'h0000_0000 &&
			cache_geometry_word_b_o == 32'h0000_0000;
	endproperty
	a_leaf_hidden: assert property (p_leaf_hidden)
		else $error("gated leaf answered while limit bit set");

	// an index past the table ends the enumeration with all words zero
	property p_null_past_end;
		@(posedge clk_i) disable iff (srst_i)
		(query_i && sub_idx_i >= 32'(cpe_pkg::CPE_NUM_LEVELS)) |=>
		cache_descriptor_word_a_o == 32'h0000_0000 && cache_geometry_word_b_o == 32'h0000_0000 &&
			cache_sets_word_c_o == 32'h0000_0000 && cache_spare_word_d_o == 32'h0000_0000;
	endproperty
	a_null_past_end: assert property (p_null_past_end)
		else $error("index past last cache not null");

	// words a and c and the stored function hold between queries
	property p_hold;
		@(posedge clk_i) disable iff (srst_i)
		!query_i |=> $stable(cache_descriptor_word_a_o) && $stable(cache_sets_word_c_o) &&
			func_r == $past(func_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("result words changed without a query");

endmodule : cpe_enumerator

// ==== pkg/cpe_pkg.sv ====
// package: constants, field layout and level table of the cache parameter enumerator
package cpe_pkg;

	// ----------------------------------------------------------------
	// query decode
	// ----------------------------------------------------------------
	localparam logic [31:0] CPE_LEAF_CACHE = 32'h0000_0004; // leaf that this block answers
	localparam logic [31:0] CPE_GATED_LO = 32'h0000_0003; // gated leaves lie above this
	localparam logic [31:0] CPE_GATED_HI = 32'h8000_0000; // and below this
	localparam int CPE_LIMIT_BIT = 22; // legacy leaf limit bit position
	localparam logic [31:0] CPE_MISC_RST = 32'h0000_0000; // limit bit clear after reset

	// ----------------------------------------------------------------
	// cache type encodings
	// ----------------------------------------------------------------
	localparam logic [4:0] CPE_TYPE_NULL = 5'h00; // no more caches
	localparam logic [4:0] CPE_TYPE_DATA = 5'h01;
	localparam logic [4:0] CPE_TYPE_INSTR = 5'h02;
	localparam logic [4:0] CPE_TYPE_UNIFIED = 5'h03;

	// ----------------------------------------------------------------
	// one cache level, every count in minus-one form
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] ctype; // cache type
		logic [2:0] level; // level, 1 nearest the core
		logic self_init; // needs no software initialisation
		logic fully_assoc; // fully associative
		logic [11:0] share_m1; // logical processors sharing, minus one
		logic [5:0] cores_m1; // cores per package, minus one
		logic [11:0] line_m1; // coherency line size in bytes, minus one
		logic [9:0] part_m1; // physical line partitions, minus one
		logic [9:0] ways_m1; // ways of associativity, minus one
		logic [31:0] sets_m1; // number of sets, minus one
	} cpe_level_t;

	// ----------------------------------------------------------------
	// implemented hierarchy; the figures are plain defaults
	// ----------------------------------------------------------------
	localparam int CPE_NUM_LEVELS = 3;
	localparam cpe_level_t CPE_LEVELS [CPE_NUM_LEVELS] = '{
		'{CPE_TYPE_DATA, 3'h1, 1'b1, 1'b0, 12'h000, 6'h00, 12'h03F, 10'h000,
			10'h007, 32'h0000_003F},
		'{CPE_TYPE_INSTR, 3'h1, 1'b1, 1'b0, 12'h000, 6'h00, 12'h03F, 10'h000,
			10'h007, 32'h0000_003F},
		'{CPE_TYPE_UNIFIED, 3'h2, 1'b1, 1'b0, 12'h001, 6'h00, 12'h03F, 10'h000,
			10'h00F, 32'h0000_03FF}
	};

endpackage : cpe_pkg

// ==== core/cpe_level_rom.sv ====
// level table lookup: selects one cache level by sub-index, null beyond the last
`timescale 1ns/100ps
module cpe_level_rom (
	input wire logic [31:0] sub_idx_i,
	output cpe_pkg::cpe_level_t level_o
);

	// ----------------------------------------------------------------
	// per-entry match and or-chain
	// ----------------------------------------------------------------
	// accumulated selection, entry 0 is all zero (the null level)
	logic [$bits(cpe_pkg::cpe_level_t)-1:0] acc [cpe_pkg::CPE_NUM_LEVELS+1];

	assign acc[0] = '0;

	// an index past the table matches nothing and yields all zero
	genvar gi;
	generate
		for (gi = 0; gi < cpe_pkg::CPE_NUM_LEVELS; gi++)
		begin : g_entry
			logic hit;
			assign hit = (sub_idx_i == 32'(gi));
			assign acc[gi+1] = acc[gi] | (hit ? cpe_pkg::CPE_LEVELS[gi] : '0);
		end
	endgenerate

	assign level_o = cpe_pkg::cpe_level_t'(acc[cpe_pkg::CPE_NUM_LEVELS]);

endmodule : cpe_level_rom

// ==== dv/cpe_testbench.sv ====
// testbench: self-checking bench for the cache parameter enumerator
`timescale 1ns/100ps
module testbench;
	// ----------------------------------------------------------------
	// stimulus, observed outputs and score counters
	// ----------------------------------------------------------------
	logic clk_i; // 250 MHz core clock
	logic srst_i;
	logic query_i;
	logic [31:0] func_sel_i;
	logic [31:0] sub_idx_i;
	logic misc_wr_i;
	logic [31:0] misc_wdata_i;
	logic [31:0] misc_rdata_o;
	logic ans_valid_o;
	logic leaf_hit_o;
	logic [31:0] word_a, word_b, word_c, word_d; // the four result words
	logic [63:0] cap_seen, cap_exp; // cache capacity, seen and expected
	logic [31:0] funcs [5] = '{32'h0, 32'h3, 32'h5, 32'h7FFF_FFFF, 32'h8000_0000};
	int miscompares;
	int cmp_count;
	cpe_pkg::cpe_level_t lv2; // third table entry, for the capacity sum

	cpe_enumerator cpe_enumerator_inst (
		.clk_i(clk_i), .srst_i(srst_i), .query_i(query_i), .func_sel_i(func_sel_i),
		.sub_idx_i(sub_idx_i), .misc_wr_i(misc_wr_i), .misc_wdata_i(misc_wdata_i),
		.misc_rdata_o(misc_rdata_o), .ans_valid_o(ans_valid_o), .leaf_hit_o(leaf_hit_o),
		.cache_descriptor_word_a_o(word_a), .cache_geometry_word_b_o(word_b),
		.cache_sets_word_c_o(word_c), .cache_spare_word_d_o(word_d)
	);

	// ----------------------------------------------------------------
	// expected words, packed from the level table by the bit layout
	// ----------------------------------------------------------------
	function automatic logic [31:0] exp_word(input logic [31:0] idx, input int sel);
		cpe_pkg::cpe_level_t lv;
		lv = '0; // past the last level every field reads zero
		if (idx < cpe_pkg::CPE_NUM_LEVELS)
		begin
			lv = cpe_pkg::CPE_LEVELS[idx];
		end
		case (sel)
			0: exp_word = {lv.cores_m1, lv.share_m1, 4'h0, lv.fully_assoc, lv.self_init,
				lv.level, lv.ctype};
			1: exp_word = {lv.ways_m1, lv.part_m1, lv.line_m1};
			default: exp_word = lv.sets_m1;
		endcase
	endfunction : exp_word

	// software side of the leaf: prefetch stride in bytes from the latest answer;
	// zero means the reported size is ignored for that cache type
	function automatic logic [31:0] pick_stride(input logic det, input logic [31:0] pf_size,
		input logic [7:0] legacy);
		pick_stride = 32'h0000_0020; // nothing known: 32 bytes
		if (det && word_a[4:0] != cpe_pkg::CPE_TYPE_DATA &&
			word_a[4:0] != cpe_pkg::CPE_TYPE_UNIFIED)
		begin
			pick_stride = 32'h0000_0000;
		end
		else if (det)
		begin
			pick_stride = (pf_size == 32'h0) ? 32'h0000_0040 : pf_size;
		end
		else if (legacy == 8'hF0 || legacy == 8'hF1)
		begin
			pick_stride = (legacy == 8'hF0) ? 32'h0000_0040 : 32'h0000_0080;
		end
	endfunction : pick_stride

	// ----------------------------------------------------------------
	// compare and access tasks; all run from the falling edge
	// ----------------------------------------------------------------
	task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp32

	// words that a hidden or foreign leaf gives are all zero
	task automatic check_words(input logic hit, input logic [31:0] idx);
		cmp32("leaf hit", {31'h0, hit}, {31'h0, leaf_hit_o});
		cmp32("word a", hit ? exp_word(idx, 0) : 32'h0, word_a);
		cmp32("word b", hit ? exp_word(idx, 1) : 32'h0, word_b);
		cmp32("word c", hit ? exp_word(idx, 2) : 32'h0, word_c);
		cmp32("word d", 32'h0, word_d);
	endtask : check_words

	// hold keeps the strobe up so the next call lands back to back
	task automatic query(input logic [31:0] func, input logic [31:0] idx, input logic hit,
		input logic hold);
		query_i = 1'b1;
		func_sel_i = func;
		sub_idx_i = idx;
		@(negedge clk_i);
		cmp32("answer strobe", 32'h1, {31'h0, ans_valid_o});
		check_words(hit, idx);
		if (!hold)
		begin
			query_i = 1'b0;
		end
	endtask : query

	// one quiet cycle: the strobe drops, the words stay put
	task automatic idle_check(input logic hit, input logic [31:0] idx);
		@(negedge clk_i);
		cmp32("strobe low", 32'h0, {31'h0, ans_valid_o});
		check_words(hit, idx);
	endtask : idle_check

	task automatic write_misc(input logic [31:0] data);
		misc_wr_i = 1'b1;
		misc_wdata_i = data;
		@(negedge clk_i);
		misc_wr_i = 1'b0;
		cmp32("misc readback", data, misc_rdata_o);
	endtask : write_misc

	task automatic do_reset();
		srst_i = 1'b1;
		repeat (5) @(negedge clk_i);
		srst_i = 1'b0;
		cmp32("misc after reset", 32'h0, misc_rdata_o);
		cmp32("strobe after reset", 32'h0, {31'h0, ans_valid_o});
		check_words(1'b0, 32'h0);
	endtask : do_reset

	task automatic complete_run();
		if (miscompares == 0 && cmp_count > 0)
		begin
			$display("TEST PASSED");
		end
		else
		begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// clock and watchdog; the tests need well under 200 cycles
	// ----------------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	initial
	begin
		#8000;
		miscompares++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		query_i = 1'b0;
		func_sel_i = 32'h0;
		sub_idx_i = 32'h0;
		misc_wr_i = 1'b0;
		misc_wdata_i = 32'h0;
		miscompares = 0;
		cmp_count = 0;
		lv2 = cpe_pkg::CPE_LEVELS[2];
		// reset spans exactly five rising edges from time zero
		do_reset();
		// walk the hierarchy back to back, then past its end
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h0, 1'b1, 1'b1);
		cmp32("first word a", 32'h0000_0121, word_a);
		// the prefetch field reads zero; the line size is never taken as the stride
		cmp32("stride data", 32'h0000_0040, pick_stride(1'b1, 32'h0, 8'h00));
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h1, 1'b1, 1'b1);
		cmp32("stride instr", 32'h0000_0000, pick_stride(1'b1, 32'h80, 8'h00));
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h2, 1'b1, 1'b1);
		cmp32("stride given", 32'h0000_0080, pick_stride(1'b1, 32'h80, 8'h00));
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h3, 1'b1, 1'b1);
		query(cpe_pkg::CPE_LEAF_CACHE, 32'hFFFF_FFFF, 1'b1, 1'b0);
		idle_check(1'b1, 32'hFFFF_FFFF);
		// without the leaf, software falls back to the legacy descriptor or 32 bytes
		cmp32("stride legacy 64", 32'h0000_0040, pick_stride(1'b0, 32'h0, 8'hF0));
		cmp32("stride legacy 128", 32'h0000_0080, pick_stride(1'b0, 32'h0, 8'hF1));
		cmp32("stride fallback", 32'h0000_0020, pick_stride(1'b0, 32'h0, 8'h00));
		// capacity from the seen fields against the table figures
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h2, 1'b1, 1'b0);
		cap_seen = (64'(word_b[31:22]) + 1) * (64'(word_b[21:12]) + 1)
			* (64'(word_b[11:0]) + 1) * (64'(word_c) + 1);
		cap_exp = (64'(lv2.ways_m1) + 1) * (64'(lv2.part_m1) + 1)
			* (64'(lv2.line_m1) + 1) * (64'(lv2.sets_m1) + 1);
		cmp32("capacity", cap_exp[31:0], cap_seen[31:0]);
		idle_check(1'b1, 32'h2);
		// other leaves are not answered by this block
		foreach (funcs[i])
		begin
			query(funcs[i], 32'h0, 1'b0, 1'b0);
			@(negedge clk_i);
		end
		// limit bit hides the leaf; a write in the query cycle comes too late
		write_misc(32'h0040_0000);
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h0, 1'b0, 1'b0);
		@(negedge clk_i);
		misc_wr_i = 1'b1;
		misc_wdata_i = 32'h0;
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h1, 1'b0, 1'b0);
		misc_wr_i = 1'b0;
		@(negedge clk_i);
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h1, 1'b1, 1'b0);
		// every other bit set, bit 22 clear: still visible
		write_misc(32'hFFBF_FFFF);
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h0, 1'b1, 1'b0);
		// second reset in mid-run clears the hiding bit again
		write_misc(32'h0040_0000);
		do_reset();
		query(cpe_pkg::CPE_LEAF_CACHE, 32'h2, 1'b1, 1'b0);
		idle_check(1'b1, 32'h2);
		complete_run();
	end
endmodule : testbench
